// ---- core/key_scan_pkg.sv ----
package key_scan_pkg;
	localparam int DRIVE_LINES       = 8;
	localparam int SENSE_LINES       = 6;
	localparam int KEY_COUNT         = 48;
	localparam int KEY_W             = 6;
	localparam int CNT_W             = 7;
	localparam int MAX_KEYS_SMALL    = 32;
	localparam int MAX_KEYS_LARGE    = 48;
	localparam int LOW_SENSE_LINES   = 4;
	localparam int PARAM_W           = 8;
	// Reset values of per-key setups
	localparam logic [7:0] DIL_RESET = 8'h02;
	localparam logic [7:0] BURST_LEN_RESET = 8'h02;
	// Fixed processing cycles after each burst (digitise and process)
	localparam logic [3:0] PROC_CYCLES = 4'h4;
	// Command and response byte encodings
	localparam logic [7:0] CMD_NOP      = 8'h00;
	localparam logic [7:0] CMD_BEGIN    = 8'h01;
	localparam logic [7:0] CMD_COMMIT   = 8'h02;
	localparam logic [7:0] CMD_COUNT    = 8'h03;
	localparam logic [7:0] CMD_DIL      = 8'h40;
	localparam logic [7:0] CMD_BURST_LEN = 8'h80;
	localparam logic [7:0] RSP_ACK      = 8'hFE;
	localparam logic [7:0] RSP_REJECT   = 8'hFD;
	localparam logic [7:0] RSP_UNKNOWN  = 8'hFC;
	typedef enum logic [1:0] {
		CMD_IDLE  = 2'b00,
		CMD_KEY   = 2'b01,
		CMD_VALUE = 2'b10
	} cmd_state_e;
	typedef enum logic [1:0] {
		SCAN_SEEK  = 2'b00,
		SCAN_BURST = 2'b01,
		SCAN_PROC  = 2'b10
	} scan_state_e;
endpackage

// ---- core/key_link_if.sv ----
`timescale 1ns/1ps
interface key_link_if;
	logic       cmd_valid;
	logic [7:0] cmd_byte;
	logic       rsp_valid;
	logic [7:0] rsp_byte;
	modport device (input cmd_valid, input cmd_byte, output rsp_valid, output rsp_byte);
	modport host   (output cmd_valid, output cmd_byte, input rsp_valid, input rsp_byte);
endinterface

// ---- core/key_scan_device.sv ----
`timescale 1ns/1ps
// How it works
// - Keys are 8 drive by 6 sense intersections
// - Key ceiling is 32 or 48 by variant
// - Unused key positions never get a burst
// - Timeslots per scan equal enabled keys with a nonzero burst length
// - Zero integrator limit disables a key
// - Small variant never exceeds 32 enabled keys
// - Small variant resets with four sense lines
// - Upper lines enabled via one atomic load
// - Single-byte commands, single-byte responses
// - Scan drive lines first, then sense line
// - Keys numbered 0..47 in scan order
// - Burst and processing finish before next key
// - Burst pulses from key's own burst length
module key_scan_device #(
	parameter bit SMALL_VARIANT = 1'b1
) (
	input  wire logic                            ref_clk_i,
	input  wire logic                            rst_b_i,
	input  wire logic                            clk_en_i,
	key_link_if.device                           link,
	output logic                                 burst_active_o,
	output logic [key_scan_pkg::KEY_W-1:0]       burst_key_o,
	output logic [2:0]                           drive_line_o,
	output logic [2:0]                           sense_line_o,
	output logic                                 burst_pulse_o,
	output logic                                 scan_done_o,
	output logic [key_scan_pkg::CNT_W-1:0]       slots_per_scan_o,
	output logic [key_scan_pkg::CNT_W-1:0]       enabled_keys_o
);
	import key_scan_pkg::*;

	localparam logic [CNT_W-1:0] MAX_KEYS = SMALL_VARIANT ? CNT_W'(MAX_KEYS_SMALL)
		: CNT_W'(MAX_KEYS_LARGE);

	// ------------------------------------------------------------
	// Setups: live and staged copies
	// ------------------------------------------------------------
	// Staging lets a whole load be checked before any key changes.
	logic [PARAM_W-1:0] dil_q              [KEY_COUNT];
	logic [PARAM_W-1:0] burst_len_q        [KEY_COUNT];
	logic [PARAM_W-1:0] dil_stage_q        [KEY_COUNT];
	logic [PARAM_W-1:0] burst_len_stage_q  [KEY_COUNT];
	logic [KEY_COUNT-1:0] en_live;
	logic [KEY_COUNT-1:0] en_stage;
	logic [CNT_W-1:0]     live_cnt;
	logic [CNT_W-1:0]     stage_cnt;

	cmd_state_e          cmd_q;
	logic [7:0]          op_q;
	logic [KEY_W-1:0]    key_q;
	logic                commit_ok;
	logic                do_commit;
	logic                do_stage;
	logic                do_begin;

	genvar g;
	generate
		for (g = 0; g < KEY_COUNT; g++) begin : g_key
			// Reset value enables only the lower sense lines on the small part
			localparam bit LOW = (g / DRIVE_LINES) < LOW_SENSE_LINES;
			localparam logic [7:0] DIL_INIT = (SMALL_VARIANT && !LOW) ? 8'h00 : DIL_RESET;
			always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					dil_q[g]       <= DIL_INIT;
					burst_len_q[g] <= BURST_LEN_RESET;
				end else if (clk_en_i && do_commit && commit_ok) begin
					dil_q[g]       <= dil_stage_q[g];
					burst_len_q[g] <= burst_len_stage_q[g];
				end
			end
			always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					dil_stage_q[g]       <= DIL_INIT;
					burst_len_stage_q[g] <= BURST_LEN_RESET;
				end else if (clk_en_i) begin
					if (do_begin || (do_commit && !commit_ok)) begin
						dil_stage_q[g]       <= dil_q[g];
						burst_len_stage_q[g] <= burst_len_q[g];
					end else if (do_stage && key_q == KEY_W'(g)) begin
						if (op_q == CMD_DIL)
							dil_stage_q[g] <= link.cmd_byte;
						else
							burst_len_stage_q[g] <= link.cmd_byte;
					end
				end
			end
			assign en_live[g]  = dil_q[g] != 8'h00;
			assign en_stage[g] = dil_stage_q[g] != 8'h00;
		end
	endgenerate

	always_comb begin
		live_cnt  = '0;
		stage_cnt = '0;
		for (int i = 0; i < KEY_COUNT; i++) begin
			live_cnt  = live_cnt + CNT_W'(en_live[i]);
			stage_cnt = stage_cnt + CNT_W'(en_stage[i]);
		end
	end
	assign commit_ok = stage_cnt <= MAX_KEYS;

	// ------------------------------------------------------------
	// Byte command port
	// ------------------------------------------------------------
	assign do_begin  = link.cmd_valid && cmd_q == CMD_IDLE && link.cmd_byte == CMD_BEGIN;
	assign do_commit = link.cmd_valid && cmd_q == CMD_IDLE && link.cmd_byte == CMD_COMMIT;
	assign do_stage  = link.cmd_valid && cmd_q == CMD_VALUE;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_q <= CMD_IDLE;
			op_q  <= CMD_NOP;
			key_q <= '0;
		end else if (clk_en_i && link.cmd_valid) begin
			case (cmd_q)
				CMD_IDLE: begin
					if (link.cmd_byte == CMD_DIL || link.cmd_byte == CMD_BURST_LEN) begin
						op_q  <= link.cmd_byte;
						cmd_q <= CMD_KEY;
					end
				end
				CMD_KEY: begin
					key_q <= (link.cmd_byte < 8'(KEY_COUNT)) ? link.cmd_byte[KEY_W-1:0]
						: KEY_W'(KEY_COUNT - 1);
					cmd_q <= CMD_VALUE;
				end
				CMD_VALUE: cmd_q <= CMD_IDLE;
				default:   cmd_q <= CMD_IDLE;
			endcase
		end
	end

	// One response byte per command byte taken
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			link.rsp_valid <= 1'b0;
			link.rsp_byte  <= 8'h00;
		end else if (clk_en_i) begin
			link.rsp_valid <= link.cmd_valid;
			if (link.cmd_valid) begin
				if (cmd_q != CMD_IDLE)
					link.rsp_byte <= RSP_ACK;
				else if (link.cmd_byte == CMD_COMMIT)
					link.rsp_byte <= commit_ok ? RSP_ACK : RSP_REJECT;
				else if (link.cmd_byte == CMD_COUNT)
					link.rsp_byte <= 8'(live_cnt);
				else if (link.cmd_byte == CMD_BEGIN || link.cmd_byte == CMD_NOP
					|| link.cmd_byte == CMD_DIL || link.cmd_byte == CMD_BURST_LEN)
					link.rsp_byte <= RSP_ACK;
				else
					link.rsp_byte <= RSP_UNKNOWN;
			end
		end
	end

	// ------------------------------------------------------------
	// Scan sequencer
	// ------------------------------------------------------------
	scan_state_e      scan_q;
	logic [KEY_W-1:0] pos_q;
	logic [7:0]       pulse_q;
	logic [3:0]       proc_q;
	logic [CNT_W-1:0] slot_q;
	logic             last_pos;

	assign last_pos = pos_q == KEY_W'(KEY_COUNT - 1);

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scan_q           <= SCAN_SEEK;
			pos_q            <= '0;
			pulse_q          <= '0;
			proc_q           <= '0;
			slot_q           <= '0;
			burst_active_o   <= 1'b0;
			burst_key_o      <= '0;
			drive_line_o     <= '0;
			sense_line_o     <= '0;
			burst_pulse_o    <= 1'b0;
			scan_done_o      <= 1'b0;
			slots_per_scan_o <= '0;
		end else if (clk_en_i) begin
			scan_done_o   <= 1'b0;
			burst_pulse_o <= 1'b0;
			case (scan_q)
				SCAN_SEEK: begin
					// Disabled positions are skipped at one cycle each, no burst
					if (en_live[pos_q] && burst_len_q[pos_q] != 8'h00) begin
						scan_q         <= SCAN_BURST;
						pulse_q        <= burst_len_q[pos_q];
						burst_active_o <= 1'b1;
						burst_key_o    <= pos_q;
						drive_line_o   <= pos_q[2:0];
						sense_line_o   <= 3'(pos_q / KEY_W'(DRIVE_LINES));
						slot_q         <= slot_q + 1'b1;
					end else if (last_pos) begin
						pos_q            <= '0;
						scan_done_o      <= 1'b1;
						slots_per_scan_o <= slot_q;
						slot_q           <= '0;
					end else begin
						pos_q <= pos_q + 1'b1;
					end
				end
				SCAN_BURST: begin
					burst_pulse_o <= 1'b1;
					pulse_q       <= pulse_q - 1'b1;
					if (pulse_q == 8'h01) begin
						scan_q <= SCAN_PROC;
						proc_q <= PROC_CYCLES;
					end
				end
				SCAN_PROC: begin
					// Flag drops here so that it still covers the last pulse
					burst_active_o <= 1'b0;
					proc_q         <= proc_q - 1'b1;
					if (proc_q == 4'h1) begin
						scan_q <= SCAN_SEEK;
						if (last_pos) begin
							pos_q            <= '0;
							scan_done_o      <= 1'b1;
							slots_per_scan_o <= slot_q;
							slot_q           <= '0;
						end else begin
							pos_q <= pos_q + 1'b1;
						end
					end
				end
				default: scan_q <= SCAN_SEEK;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			enabled_keys_o <= '0;
		else if (clk_en_i)
			enabled_keys_o <= live_cnt;
	end
endmodule

// ---- core/key_scan_host.sv ----
`timescale 1ns/1ps
module key_scan_host (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        clk_en_i,
	key_link_if.host         link,
	input  wire logic        req_valid_i,
	input  wire logic [7:0]  req_byte_i,
	output logic             req_ready_o,
	output logic             rsp_valid_o,
	output logic [7:0]       rsp_byte_o
);
	import key_scan_pkg::*;

	// ------------------------------------------------------------
	// One byte outstanding at a time
	// ------------------------------------------------------------
	// The user sequences BEGIN, setups and COMMIT as one load
	logic busy_q;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			link.cmd_valid <= 1'b0;
			link.cmd_byte  <= 8'h00;
			busy_q         <= 1'b0;
			req_ready_o    <= 1'b1;
		end else if (clk_en_i) begin
			link.cmd_valid <= 1'b0;
			if (req_valid_i && !busy_q) begin
				link.cmd_valid <= 1'b1;
				link.cmd_byte  <= req_byte_i;
				busy_q         <= 1'b1;
				req_ready_o    <= 1'b0;
			end else if (link.rsp_valid) begin
				busy_q      <= 1'b0;
				req_ready_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rsp_valid_o <= 1'b0;
			rsp_byte_o  <= 8'h00;
		end else if (clk_en_i) begin
			rsp_valid_o <= link.rsp_valid;
			if (link.rsp_valid)
				rsp_byte_o <= link.rsp_byte;
		end
	end

	// Disabled keys are written with a zero limit
endmodule

// ---- tb/key_link_checker.sv ----
`timescale 1ns/1ps
// ----------------------------
// Link and scan checker
// ----------------------------
module key_link_checker (
	input wire logic                          ref_clk_i,
	input wire logic                          rst_b_i,
	input wire logic                          clk_en_i,
	input wire logic                          cmd_valid,
	input wire logic                          rsp_valid,
	input wire logic                          burst_active_o,
	input wire logic [key_scan_pkg::KEY_W-1:0] burst_key_o,
	input wire logic [2:0]                    drive_line_o,
	input wire logic [2:0]                    sense_line_o,
	input wire logic                          burst_pulse_o,
	input wire logic                          scan_done_o,
	input wire logic [key_scan_pkg::CNT_W-1:0] enabled_keys_o
);
	import key_scan_pkg::*;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	chk_rsp_follows_cmd: assert property (cmd_valid && clk_en_i |=> rsp_valid)
		else $error("no response one cycle after command");
	chk_no_stray_rsp: assert property (rsp_valid |-> $past(cmd_valid))
		else $error("response without command");
	chk_lines_map_key: assert property (burst_active_o |->
		drive_line_o == burst_key_o[2:0] && sense_line_o == burst_key_o[5:3])
		else $error("drive or sense line does not match key");
	chk_key_in_range: assert property (burst_active_o |-> burst_key_o <= 6'h2F)
		else $error("burst key above 47");
	chk_count_ceiling: assert property (enabled_keys_o <= MAX_KEYS_SMALL)
		else $error("enabled keys above ceiling");
	chk_pulse_in_burst: assert property (burst_pulse_o |-> burst_active_o)
		else $error("burst pulse outside burst");
	chk_proc_gap: assert property ($fell(burst_active_o) |-> !burst_active_o [*4])
		else $error("next burst before processing finished");
	chk_done_single: assert property (scan_done_o && clk_en_i |=> !scan_done_o)
		else $error("scan done longer than one cycle");
endmodule

// ---- tb/touch_matrix_key_scan_enable_test.sv ----
`timescale 1ns/1ps
// ----------------------------
// Bench: host end facing device end
// ----------------------------
module touch_matrix_key_scan_enable_test;
	import key_scan_pkg::*;
	logic ref_clk_i = 0, rst_b_i = 0, clk_en_i = 1, req_valid_i = 0, stale = 1;
	logic act_q = 0, done_q = 0, req_ready_o, rsp_valid_o, burst_active_o;
	logic burst_pulse_o, scan_done_o, seq_ok = 0;
	logic [7:0] req_byte_i = 8'h00, pc = 8'h00, rsp_byte_o, r8, hold;
	logic [7:0] lim_m [48], burst_m [48], st_l [48], st_b [48];
	logic [KEY_W-1:0] k_q = 6'h00, burst_key_o;
	logic [2:0] drive_line_o, sense_line_o;
	logic [CNT_W-1:0] slots_per_scan_o, enabled_keys_o;
	logic [31:0] seed = 32'h57, r;
	int error_cnt = 0, tests_run = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	key_link_if link_bus ();
	key_scan_device key_scan_device_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i), .link(link_bus), .burst_active_o(burst_active_o),
		.burst_key_o(burst_key_o), .drive_line_o(drive_line_o),
		.sense_line_o(sense_line_o), .burst_pulse_o(burst_pulse_o),
		.scan_done_o(scan_done_o), .slots_per_scan_o(slots_per_scan_o),
		.enabled_keys_o(enabled_keys_o));
	key_scan_host key_scan_host_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i), .link(link_bus), .req_valid_i(req_valid_i),
		.req_byte_i(req_byte_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_byte_o(rsp_byte_o));
	key_link_checker key_link_checker_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.clk_en_i(clk_en_i), .cmd_valid(link_bus.cmd_valid),
		.rsp_valid(link_bus.rsp_valid), .burst_active_o(burst_active_o),
		.burst_key_o(burst_key_o), .drive_line_o(drive_line_o),
		.sense_line_o(sense_line_o), .burst_pulse_o(burst_pulse_o),
		.scan_done_o(scan_done_o), .enabled_keys_o(enabled_keys_o));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [7:0] cnt(input logic [7:0] l [48]);
		logic [7:0] n;
		n = 8'h00;
		foreach (l[i]) if (l[i] != 8'h00) n++;
		return n;
	endfunction
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task end_sim();
		if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task model_rst();
		foreach (lim_m[i]) begin
			lim_m[i] = (i < LOW_SENSE_LINES * DRIVE_LINES) ? DIL_RESET : 8'h00;
			burst_m[i] = BURST_LEN_RESET;
		end
	endtask
	task xf(input logic [7:0] b, input logic [7:0] e);
		int i;
		chk("ready idle", 8'h01, {7'h00, req_ready_o});
		@(posedge ref_clk_i) begin req_valid_i <= 1; req_byte_i <= b; end
		@(posedge ref_clk_i) req_valid_i <= 0;
		@(negedge ref_clk_i) chk("ready busy", 8'h00, {7'h00, req_ready_o});
		for (i = 0; i < 60 && rsp_valid_o !== 1'b1; i++) @(negedge ref_clk_i);
		if (i == 60) begin
			chk("timeout", 8'h01, 8'h00);
			end_sim();
		end else begin
			chk("response", e, rsp_byte_o);
			chk("latency", 8'h02, 8'(i));
		end
	endtask
	task bg();
		xf(CMD_BEGIN, RSP_ACK);
		st_l = lim_m;
		st_b = burst_m;
	endtask
	task setp(input logic [7:0] op, input logic [7:0] k, input logic [7:0] v);
		int j;
		j = (k > 8'h2F) ? 47 : int'(k);
		xf(op, RSP_ACK);
		xf(k, RSP_ACK);
		xf(v, RSP_ACK);
		if (op == CMD_DIL) st_l[j] = v;
		else st_b[j] = v;
	endtask
	task commit();
		logic ok;
		ok = cnt(st_l) <= MAX_KEYS_SMALL;
		stale = 1;
		xf(CMD_COMMIT, ok ? RSP_ACK : RSP_REJECT);
		// A scan end inside the command must not clear the straddle guard
		stale = 1;
		if (ok) begin lim_m = st_l; burst_m = st_b; end
	endtask
	task scans();
		int i, n;
		n = 0;
		for (i = 0; i < 6000 && n < 2; i++) begin
			@(negedge ref_clk_i);
			if (scan_done_o === 1'b1) n++;
		end
		if (n < 2) begin chk("scan", 8'h01, 8'h00); end_sim(); end
	endtask
	// Skips bursts and scans that may straddle a commit
	always @(negedge ref_clk_i) begin
		if (burst_pulse_o === 1'b1) pc++;
		if (!act_q && burst_active_o === 1'b1) begin
			if (seq_ok && !stale) chk("order", 8'h01, {7'h00, burst_key_o > k_q});
			seq_ok = 1;
		end
		if (act_q && burst_active_o === 1'b0) begin
			if (!stale) chk("pulses", burst_m[k_q], pc);
			if (!stale) chk("burst on used", 8'h01, {7'h00, lim_m[k_q] != 8'h00});
			pc = 8'h00;
		end
		if (done_q) begin
			if (!stale) chk("slots", cnt(lim_m), {1'b0, slots_per_scan_o});
			stale = 0;
		end
		if (scan_done_o === 1'b1) seq_ok = 0;
		act_q = burst_active_o === 1'b1;
		done_q = scan_done_o === 1'b1;
		k_q = burst_key_o;
	end
	initial begin
		model_rst();
		repeat (5) @(posedge ref_clk_i);
		rst_b_i <= 1;
		xf(CMD_COUNT, 8'h20);
		scans();
		// Enable low mid-scan: burst flag, burst pulse and burst key must hold
		@(posedge ref_clk_i) clk_en_i <= 0;
		stale = 1;
		@(negedge ref_clk_i) hold = {burst_active_o, burst_pulse_o, burst_key_o};
		repeat (6) @(negedge ref_clk_i);
		chk("frozen", hold, {burst_active_o, burst_pulse_o, burst_key_o});
		@(posedge ref_clk_i) clk_en_i <= 1;
		xf(8'h33, RSP_UNKNOWN);
		xf(CMD_NOP, RSP_ACK);
		bg();
		setp(CMD_DIL, 8'h28, 8'h05);
		commit();
		bg();
		setp(CMD_DIL, 8'h00, 8'h00);
		setp(CMD_DIL, 8'h28, 8'h03);
		setp(CMD_BURST_LEN, 8'h3F, 8'h05);
		commit();
		scans();
		repeat (12) begin
			bg();
			repeat (1 + xs() % 3) begin
				r = xs();
				r8 = r[0] ? {6'h00, r[17:16]} : {5'h00, r[18:16] | 3'h1};
				setp(r[0] ? CMD_DIL : CMD_BURST_LEN, {2'h0, r[13:8]}, r8);
			end
			commit();
			scans();
			chk("enabled", cnt(lim_m), {1'b0, enabled_keys_o});
			xf(CMD_COUNT, cnt(lim_m));
		end
		// Second reset after reconfiguration: setups return to defaults
		@(posedge ref_clk_i) rst_b_i <= 0;
		stale = 1;
		@(negedge ref_clk_i);
		chk("reset outputs", 8'h01, {3'h0, burst_active_o, burst_pulse_o, scan_done_o,
			rsp_valid_o, req_ready_o});
		chk("reset count", 8'h00, {1'b0, enabled_keys_o});
		@(posedge ref_clk_i) rst_b_i <= 1;
		model_rst();
		xf(CMD_COUNT, 8'h20);
		scans();
		end_sim();
	end
endmodule
